// [core/tcomp_pkg.sv]
// constants for the temperature driven frequency compensation block
//==============================================================
// Contract
// - correction value is recomputed once every 32 seconds from latest inputs
// - correction inserts or removes single 32.768 kHz pulses over a 32 s period
// - calculation uses offset, turnover temperature, quadratic coefficient and temperature
// - control bit 1 enables the thermometer, bit 0 selects scan interval
// - scan select 0 measures every second, 1 every 16 seconds
// - each finished measurement lands in the readable 8-bit temperature register
// - temperature code is unsigned, 1 degree per step, 60 means 0 degrees
// - low voltage one flag stops the thermometer, value frozen, compensation continues
// - offset bit 7 is sign (1 faster), bits 6..0 magnitude 0 to 121
// - offset cancels the initial frequency error at turnover temperature
// - quadratic coefficient 0 to 255 cancels the parabolic drift with temperature
// - turnover register uses bits 5..0, bits 7..6 unused
// - one correction pulse per 32 second period shifts the rate by 1 ppm
// - raw 32.768 kHz output uncorrected, prescaler 1024/32/1 Hz taps corrected
package tcomp_pkg;
    //==============================================================
    // register map
    localparam logic [7:0] ADDR_TEMP    = 8'h20;
    localparam logic [7:0] ADDR_CTRL    = 8'h30;
    localparam logic [7:0] ADDR_OFFSET  = 8'h31;
    localparam logic [7:0] ADDR_COEF    = 8'h32;
    localparam logic [7:0] ADDR_T0      = 8'h33;
    localparam int         CTRL_SCAN_BIT = 0;
    localparam int         CTRL_THERM_BIT = 1;
    localparam int         OFFSET_SIGN_BIT = 7;
    localparam int         T0_W         = 6;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    //==============================================================
    // reset values
    localparam logic [7:0] TEMP_RESET   = 8'h55;
    localparam logic [7:0] CTRL_RESET   = 8'h02;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [7:0] COEF_RESET   = 8'h00;
    localparam logic [5:0] T0_RESET     = 6'h15;
    //==============================================================
    // arithmetic
    localparam int         TEMP_ZERO_CODE = 60;
    localparam int         T0_BIAS      = 4;
    localparam logic signed [8:0] DIFF_BIAS = 9'sh040;
    localparam int         COEF_SHIFT   = 12;
    localparam int         CORR_W       = 13;
    //==============================================================
    // timing: oscillator rate in Hz, periods in seconds, prescaler width and tap bits
    localparam int         OSC_HZ       = 32768;
    localparam int         COMP_PERIOD_S = 32;
    localparam int         SCAN_FAST_S  = 1;
    localparam int         SCAN_SLOW_S  = 16;
    localparam int         PRESC_W      = 15;
    localparam int         TAP_1024HZ   = 4;
    localparam int         TAP_32HZ     = 9;
    localparam int         TAP_1HZ      = 14;
endpackage

// [core/freq_correction_engine.sv]
// correction value calculator of the compensation block
`timescale 1ns/10ps
module freq_correction_engine (
    input  wire logic                     clk_in,
    input  wire logic                     reset_in,
    input  wire logic                     start_in,
    input  wire logic [7:0]               temp_in,
    input  wire logic [7:0]               offset_in,
    input  wire logic [7:0]               coef_in,
    input  wire logic [5:0]               t0_in,
    output logic                          done_out,
    output logic signed [tcomp_pkg::CORR_W-1:0] corr_out
);
    //==============================================================
    // state
    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_CALC = 3'b010,
        ENG_DONE = 3'b100
    } eng_state_t;

    typedef struct packed {
        eng_state_t                          st;
        logic signed [8:0]                   diff;
        logic signed [tcomp_pkg::CORR_W-1:0] corr;
    } eng_t;

    eng_t s;
    eng_t next_s;

    // squared distance from turnover, times the coefficient, shifted down by COEF_SHIFT bits
    function automatic logic signed [tcomp_pkg::CORR_W-1:0] quad_term(input logic signed [8:0] d,
                                                                       input logic [7:0] c);
        logic [15:0] sq;
        logic [23:0] p;
        sq = 16'(d * d);
        p  = {8'h00, sq} * {16'h0000, c};
        return $signed({1'b0, p[23:tcomp_pkg::COEF_SHIFT]});
    endfunction

    // slow crystal needs extra pulses, fast crystal loses some
    function automatic logic signed [tcomp_pkg::CORR_W-1:0] offset_term(input logic [7:0] o);
        logic signed [tcomp_pkg::CORR_W-1:0] mag;
        mag = $signed({6'h00, o[6:0]});
        return o[tcomp_pkg::OFFSET_SIGN_BIT] ? -mag : mag;
    endfunction

    //==============================================================
    // next state
    always_comb begin
        next_s = s;
        case (s.st)
            ENG_IDLE: begin
                if (start_in) begin
                    // code minus 60 minus (t0 plus 4)
                    next_s.diff = $signed({1'b0, temp_in}) - tcomp_pkg::DIFF_BIAS
                                  - $signed({3'b000, t0_in});
                    next_s.st   = ENG_CALC;
                end
            end
            ENG_CALC: begin
                // parabola is negative drift, so it always adds pulses
                next_s.corr = offset_term(offset_in) + quad_term(s.diff, coef_in);
                next_s.st   = ENG_DONE;
            end
            ENG_DONE: begin
                next_s.st = ENG_IDLE;
            end
            default: begin
                next_s.st = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s <= '{st: ENG_IDLE, diff: '0, corr: '0};
        end else begin
            s <= next_s;
        end
    end

    assign done_out = (s.st == ENG_DONE);
    assign corr_out = s.corr;

    //==============================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    engine_latency_a: assert property (start_in && s.st == ENG_IDLE |-> ##2 done_out)
        else $error("engine did not finish two cycles after start");
endmodule

// [core/temp_freq_compensation.sv]
// temperature driven frequency compensation with thermometer and prescaler
`timescale 1ns/10ps
module temp_freq_compensation #(
    parameter int COMP_TICKS      = tcomp_pkg::OSC_HZ * tcomp_pkg::COMP_PERIOD_S,
    parameter int SCAN_FAST_TICKS = tcomp_pkg::OSC_HZ * tcomp_pkg::SCAN_FAST_S,
    parameter int SCAN_SLOW_TICKS = tcomp_pkg::OSC_HZ * tcomp_pkg::SCAN_SLOW_S
) (
    input  wire logic                     clk_in,
    input  wire logic                     reset_in,
    input  wire logic                     osc_level_in,
    input  wire logic [7:0]               sensor_temp_in,
    input  wire logic                     low_voltage_one_flag_in,
    input  wire logic [7:0]               reg_addr_in,
    input  wire logic                     reg_write_in,
    input  wire logic [7:0]               reg_wdata_in,
    output logic [7:0]                    reg_rdata_out,
    output logic                          ref_32k_out,
    output logic                          hz1024_out,
    output logic                          hz32_out,
    output logic                          hz1_out,
    output logic signed [tcomp_pkg::CORR_W-1:0] correction_out
);
    localparam int CNT_W = $clog2(COMP_TICKS > SCAN_SLOW_TICKS ? COMP_TICKS : SCAN_SLOW_TICKS) + 1;
    localparam int CW    = tcomp_pkg::CORR_W;

    //==============================================================
    // state
    typedef struct packed {
        logic                               osc;
        logic [7:0]                         temp;
        logic [7:0]                         ctrl;
        logic [7:0]                         offs;
        logic [7:0]                         coef;
        logic [tcomp_pkg::T0_W-1:0]         t0;
        logic [CNT_W-1:0]                   period_cnt;
        logic [CNT_W-1:0]                   scan_cnt;
        logic [CNT_W:0]                     acc;
        logic signed [CW-1:0]               corr;
        logic [tcomp_pkg::PRESC_W-1:0]      presc;
        logic [7:0]                         rdata;
    } comp_state_t;

    comp_state_t s;
    comp_state_t next_s;

    logic                 tick;
    logic                 period_end;
    logic                 scan_hit;
    logic                 therm_on;
    logic                 take_sample;
    logic                 write_temp;
    logic [CNT_W-1:0]     scan_last;
    logic [CW-1:0]        corr_mag;
    logic [CNT_W:0]       acc_sum;
    logic                 fire;
    logic                 insert;
    logic                 remove;
    logic                 eng_done;
    logic signed [CW-1:0] eng_corr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    //==============================================================
    // decode
    assign tick        = osc_level_in && !s.osc;
    assign period_end  = tick && (s.period_cnt == CNT_W'(COMP_TICKS - 1));
    assign scan_last   = s.ctrl[tcomp_pkg::CTRL_SCAN_BIT] ? CNT_W'(SCAN_SLOW_TICKS - 1)
                                                          : CNT_W'(SCAN_FAST_TICKS - 1);
    assign scan_hit    = tick && (s.scan_cnt >= scan_last);
    assign therm_on    = s.ctrl[tcomp_pkg::CTRL_THERM_BIT] && !low_voltage_one_flag_in;
    assign take_sample = scan_hit && therm_on;
    // software value only lands while the thermometer is off
    assign write_temp  = reg_write_in && hit(reg_addr_in, tcomp_pkg::ADDR_TEMP)
                         && !s.ctrl[tcomp_pkg::CTRL_THERM_BIT];
    assign corr_mag    = s.corr[CW-1] ? CW'(-s.corr) : CW'(s.corr);
    // spreads |corr| pulses evenly over the period, one pulse is about 1 ppm
    assign acc_sum     = s.acc + (CNT_W + 1)'(corr_mag);
    assign fire        = tick && (acc_sum >= (CNT_W + 1)'(COMP_TICKS));
    assign insert      = fire && !s.corr[CW-1];
    assign remove      = fire && s.corr[CW-1];

    //==============================================================
    // correction engine, fed with the held temperature
    freq_correction_engine u_engine (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .start_in  (period_end),
        .temp_in   (s.temp),
        .offset_in (s.offs),
        .coef_in   (s.coef),
        .t0_in     (s.t0),
        .done_out  (eng_done),
        .corr_out  (eng_corr)
    );

    //==============================================================
    // next state
    always_comb begin
        next_s     = s;
        next_s.osc = osc_level_in;
        if (tick) begin
            next_s.period_cnt = period_end ? '0 : s.period_cnt + 1'b1;
            next_s.scan_cnt   = scan_hit ? '0 : s.scan_cnt + 1'b1;
            next_s.acc        = fire ? acc_sum - (CNT_W + 1)'(COMP_TICKS) : acc_sum;
            if (insert) begin
                next_s.presc = s.presc + tcomp_pkg::PRESC_W'(2);
            end else if (!remove) begin
                next_s.presc = s.presc + 1'b1; // a removed pulse leaves it standing
            end
        end
        if (reg_write_in) begin
            case (reg_addr_in)
                tcomp_pkg::ADDR_CTRL:   next_s.ctrl = reg_wdata_in;
                tcomp_pkg::ADDR_OFFSET: next_s.offs = reg_wdata_in;
                tcomp_pkg::ADDR_COEF:   next_s.coef = reg_wdata_in;
                tcomp_pkg::ADDR_T0:     next_s.t0   = reg_wdata_in[tcomp_pkg::T0_W-1:0];
                default: begin
                end
            endcase
        end
        if (write_temp) begin
            next_s.temp = reg_wdata_in;
        end
        // measurement wins; it cannot meet a software write since that needs the enable low
        if (take_sample) begin
            next_s.temp = sensor_temp_in;
        end
        if (eng_done) begin
            next_s.corr = eng_corr;
        end
        case (reg_addr_in)
            tcomp_pkg::ADDR_TEMP:   next_s.rdata = s.temp;
            tcomp_pkg::ADDR_CTRL:   next_s.rdata = s.ctrl;
            tcomp_pkg::ADDR_OFFSET: next_s.rdata = s.offs;
            tcomp_pkg::ADDR_COEF:   next_s.rdata = s.coef;
            tcomp_pkg::ADDR_T0:     next_s.rdata = {2'b00, s.t0};
            default:                next_s.rdata = tcomp_pkg::UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s <= '{osc: 1'b0,
                   temp: tcomp_pkg::TEMP_RESET,
                   ctrl: tcomp_pkg::CTRL_RESET,
                   offs: tcomp_pkg::OFFSET_RESET,
                   coef: tcomp_pkg::COEF_RESET,
                   t0: tcomp_pkg::T0_RESET,
                   period_cnt: '0,
                   scan_cnt: '0,
                   acc: '0,
                   corr: '0,
                   presc: '0,
                   rdata: tcomp_pkg::UNMAPPED_DATA};
        end else begin
            s <= next_s;
        end
    end

    //==============================================================
    // outputs
    assign reg_rdata_out  = s.rdata;
    // registered copy of the oscillator level, never sees correction pulses
    assign ref_32k_out    = s.osc;
    assign hz1024_out     = s.presc[tcomp_pkg::TAP_1024HZ];
    assign hz32_out       = s.presc[tcomp_pkg::TAP_32HZ];
    assign hz1_out        = s.presc[tcomp_pkg::TAP_1HZ];
    assign correction_out = s.corr;

    //==============================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    period_recompute_a: assert property (period_end |-> ##3 s.corr == $past(eng_corr))
        else $error("correction not loaded after period end");

    corr_hold_a: assert property (!eng_done |=> $stable(s.corr))
        else $error("correction changed outside a recompute");

    insert_step_a: assert property (insert |=> s.presc == $past(s.presc) + tcomp_pkg::PRESC_W'(2))
        else $error("inserted pulse did not advance prescaler by two");

    remove_hold_a: assert property (remove |=> $stable(s.presc))
        else $error("removed pulse still advanced prescaler");

    scan_store_a: assert property (scan_hit && s.ctrl[tcomp_pkg::CTRL_THERM_BIT] && !low_voltage_one_flag_in
                                   |=> s.temp == $past(sensor_temp_in))
        else $error("measurement not stored at scan");

    freeze_lv_a: assert property (low_voltage_one_flag_in && !write_temp |=> $stable(s.temp))
        else $error("temperature changed under low voltage");

    disabled_keep_a: assert property (!s.ctrl[tcomp_pkg::CTRL_THERM_BIT] && !write_temp |=> $stable(s.temp))
        else $error("temperature changed with thermometer off");

    scan_interval_a: assert property (tick && s.ctrl[tcomp_pkg::CTRL_SCAN_BIT]
                                      && s.scan_cnt < CNT_W'(SCAN_SLOW_TICKS - 1)
                                      |-> !scan_hit)
        else $error("slow scan fired early");

    ref_direct_a: assert property (##1 ref_32k_out == $past(osc_level_in))
        else $error("raw reference output not direct");

    t0_upper_a: assert property (reg_addr_in == tcomp_pkg::ADDR_T0 |=> reg_rdata_out[7:6] == 2'b00)
        else $error("unused turnover bits read nonzero");

    pulse_rate_a: assert property (fire |=> !fire)
        else $error("two correction pulses back to back");

    cover_insert_c:  cover property (insert);
    cover_remove_c:  cover property (remove);
    cover_sample_c:  cover property (take_sample);
    cover_period_c:  cover property (period_end ##3 s.corr != 0);
endmodule

// [sim/temp_freq_compensation_tb_top.sv]
// self-checking testbench for the temperature driven frequency compensation block
`timescale 1ns/10ps
module temp_freq_compensation_tb_top;
    //==============================================================
    // design ports and bench counters
    logic                                clk_in = 1'b0;
    logic                                reset_in = 1'b1;
    logic                                osc_level_in = 1'b0;
    logic [7:0]                          sensor_temp_in = 8'h00;
    logic                                low_voltage_one_flag_in = 1'b0;
    logic [7:0]                          reg_addr_in = 8'h00;
    logic                                reg_write_in = 1'b0;
    logic [7:0]                          reg_wdata_in = 8'h00;
    logic [7:0]                          reg_rdata_out;
    logic                                ref_32k_out;
    logic                                hz1024_out;
    logic                                hz32_out;
    logic                                hz1_out;
    logic signed [tcomp_pkg::CORR_W-1:0] correction_out;
    int                                  n_mismatch = 0;
    int                                  compares = 0;
    int                                  cycles = 0;
    int                                  n_edge = 0;
    int                                  n_ref = 0;
    logic                                last_h = 1'b0;
    logic                                last_r = 1'b0;
    int                                  n_e32 = 0;
    int                                  n_e1 = 0;
    logic                                last_32 = 1'b0;
    logic                                last_1 = 1'b0;
    // test table: temperature, offset, coefficient, turnover; then expected correction
    // values stand in for factory parameters, scaled as software must store them
    logic [7:0]                          cs [4][4] = '{'{8'h69, 8'h85, 8'hFF, 8'h15}, '{8'h41, 8'h0A, 8'hFF, 8'h15},
                                                       '{8'h3C, 8'h94, 8'h00, 8'h3F}, '{8'h3C, 8'hF9, 8'h00, 8'h3F}};
    int                                  ce [4] = '{19, 34, -20, -121};
    logic [7:0]                          ra [6] = '{tcomp_pkg::ADDR_TEMP, tcomp_pkg::ADDR_CTRL, tcomp_pkg::ADDR_OFFSET,
                                                    tcomp_pkg::ADDR_COEF, tcomp_pkg::ADDR_T0, 8'h34};
    logic [7:0]                          rv [6] = '{tcomp_pkg::TEMP_RESET, tcomp_pkg::CTRL_RESET, tcomp_pkg::OFFSET_RESET,
                                                    tcomp_pkg::COEF_RESET, {2'b00, tcomp_pkg::T0_RESET},
                                                    tcomp_pkg::UNMAPPED_DATA};

    always #25 clk_in = ~clk_in;

    // short counts keep the run small; expectations derive from 64 ticks per period
    temp_freq_compensation #(.COMP_TICKS(64), .SCAN_FAST_TICKS(4), .SCAN_SLOW_TICKS(16)) dut (
        .clk_in                  (clk_in),
        .reset_in                (reset_in),
        .osc_level_in            (osc_level_in),
        .sensor_temp_in          (sensor_temp_in),
        .low_voltage_one_flag_in (low_voltage_one_flag_in),
        .reg_addr_in             (reg_addr_in),
        .reg_write_in            (reg_write_in),
        .reg_wdata_in            (reg_wdata_in),
        .reg_rdata_out           (reg_rdata_out),
        .ref_32k_out             (ref_32k_out),
        .hz1024_out              (hz1024_out),
        .hz32_out                (hz32_out),
        .hz1_out                 (hz1_out),
        .correction_out          (correction_out)
    );

    //==============================================================
    // edge counting and hang guard
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        last_h <= hz1024_out;
        last_r <= ref_32k_out;
        last_32 <= hz32_out;
        last_1 <= hz1_out;
        // no counting before the taps leave their unknown power-up state
        if (!reset_in && hz1024_out !== last_h) n_edge <= n_edge + 1;
        if (!reset_in && hz32_out !== last_32) n_e32 <= n_e32 + 1;
        if (!reset_in && hz1_out !== last_1) n_e1 <= n_e1 + 1;
        if (ref_32k_out === 1'b1 && last_r === 1'b0) n_ref <= n_ref + 1;
        if (cycles == 30000) begin
            $display("MISMATCH run length expected below 30000 seen 30000");
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end

    //==============================================================
    // access tasks
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic range_chk(string what, int lo, int hi, int got);
        compares++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_write_in = 1'b1;
        @(negedge clk_in);
        reg_write_in = 1'b0;
    endtask

    task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
        @(negedge clk_in);
        reg_addr_in = a;
        @(negedge clk_in);
        check($sformatf("register %h", a), {8'h00, exp}, {8'h00, reg_rdata_out});
    endtask

    // one oscillator tick every two system cycles, then let the pipeline settle
    task automatic ticks(int n);
        repeat (n) begin
            @(negedge clk_in);
            osc_level_in = 1'b1;
            @(negedge clk_in);
            osc_level_in = 1'b0;
        end
        repeat (3) @(negedge clk_in);
    endtask

    // catch one scan, then show the next comes after lim ticks, not before
    task automatic scan_period(logic [7:0] ctrl, int lim, logic [7:0] a, logic [7:0] b);
        int k;
        k = 0;
        wr(tcomp_pkg::ADDR_CTRL, ctrl);
        sensor_temp_in = a;
        reg_addr_in = tcomp_pkg::ADDR_TEMP;
        while (reg_rdata_out !== a && k < 40) begin
            ticks(1);
            k++;
        end
        check("scan catch", {8'h00, a}, {8'h00, reg_rdata_out});
        sensor_temp_in = b;
        ticks(lim - 1);
        check("scan early", {8'h00, a}, {8'h00, reg_rdata_out});
        ticks(2);
        check("scan due", {8'h00, b}, {8'h00, reg_rdata_out});
    endtask

    //==============================================================
    // main sequence
    initial begin
        int e0;
        int r0;
        int k;
        int c;
        repeat (8) @(negedge clk_in);
        reset_in = 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i]);
        wr(tcomp_pkg::ADDR_TEMP, 8'h99);
        rd_chk(tcomp_pkg::ADDR_TEMP, tcomp_pkg::TEMP_RESET);
        wr(8'h34, 8'hAA);
        rd_chk(8'h34, tcomp_pkg::UNMAPPED_DATA);
        wr(tcomp_pkg::ADDR_OFFSET, 8'h85);
        wr(tcomp_pkg::ADDR_COEF, 8'hA5);
        wr(tcomp_pkg::ADDR_T0, 8'hFF);
        rd_chk(tcomp_pkg::ADDR_OFFSET, 8'h85);
        rd_chk(tcomp_pkg::ADDR_COEF, 8'hA5);
        rd_chk(tcomp_pkg::ADDR_T0, 8'h3F);
        wr(tcomp_pkg::ADDR_CTRL, 8'hFD);
        rd_chk(tcomp_pkg::ADDR_CTRL, 8'hFD);
        scan_period(8'h02, 4, 8'h3C, 8'h00);
        scan_period(8'h03, 16, 8'hFA, 8'h47);
        low_voltage_one_flag_in = 1'b1;
        sensor_temp_in = 8'h12;
        ticks(20);
        rd_chk(tcomp_pkg::ADDR_TEMP, 8'h47);
        low_voltage_one_flag_in = 1'b0;
        wr(tcomp_pkg::ADDR_CTRL, 8'h00);
        ticks(20);
        rd_chk(tcomp_pkg::ADDR_TEMP, 8'h47);
        for (int i = 0; i < 4; i++) begin
            wr(tcomp_pkg::ADDR_TEMP, cs[i][0]);
            wr(tcomp_pkg::ADDR_OFFSET, cs[i][1]);
            wr(tcomp_pkg::ADDR_COEF, cs[i][2]);
            wr(tcomp_pkg::ADDR_T0, cs[i][3]);
            k = 0;
            // a full period of 64 ticks must be enough for the new value
            while (correction_out !== 13'(ce[i]) && k < 70) begin
                ticks(1);
                k++;
            end
            check("correction", 16'(ce[i]), 16'(correction_out));
            if (ce[i] > -64 && ce[i] < 64) begin
                c = ce[i];
                e0 = n_edge;
                r0 = n_ref;
                ticks(512);
                check("raw edges", 16'd512, 16'(n_ref - r0));
                range_chk("1024 Hz edges", (512 + 8 * c) / 16 - 1, (512 + 8 * c) / 16 + 1, n_edge - e0);
            end
        end
        // both taps come off one prescaler, 32 Hz is the 1024 Hz tap divided by 32
        check("32 Hz edges", 16'(n_edge / 32), 16'(n_e32));
        check("1 Hz edges", 16'(n_edge / 1024), 16'(n_e1));
        final_report();
    end
endmodule
